// ### rtl/sebp_pkg.sv
// Constants for the serial EEPROM bus front end and its status register.
// Assumes one 250 MHz system clock; every link pin is sampled by that clock.
package sebp_pkg;
   // System clock
   localparam int unsigned CLK_PERIOD_NS = 4;
   // Self-timed write cycle; the real figure is not given, so a plain default
   localparam int unsigned WRITE_TIME_NS = 5000000;
   localparam int unsigned WR_CYCLES_DFLT = WRITE_TIME_NS / CLK_PERIOD_NS;
   // Array geometry, 512 x 8
   localparam int unsigned ADDR_W = 9;
   // Status byte layout
   localparam logic [3:0] STAT_ONES = 4'hF;
   localparam int unsigned STAT_PSEL_HI = 3;
   localparam int unsigned STAT_PSEL_LO = 2;
   localparam int unsigned STAT_WEL = 1;
   localparam int unsigned STAT_BUSY = 0;
   // Reset value of the protect selection (non-volatile in silicon)
   localparam logic [1:0] PSEL_RST = 2'h0;
   // Instruction byte: upper nibble must be zero, bit 3 is don't care or A8
   localparam logic [3:0] OP_HI = 4'h0;
   localparam logic [2:0] OP_LATCH_SET = 3'h6;
   localparam logic [2:0] OP_LATCH_CLEAR = 3'h4;
   localparam logic [2:0] OP_STATUS_READ = 3'h5;
   localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
   localparam logic [2:0] OP_ARRAY_READ = 3'h3;
   localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Interface sequencing
   typedef enum logic [2:0] {
      SEBP_CMD = 3'b000,
      SEBP_ADDR = 3'b001,
      SEBP_DATA = 3'b010,
      SEBP_OUT = 3'b011,
      SEBP_WAIT = 3'b100,
      SEBP_IGN = 3'b101
   } sebp_state_t;

   // Instruction awaiting deselect
   typedef enum logic [2:0] {
      SEBP_C_NONE = 3'b000,
      SEBP_C_SET = 3'b001,
      SEBP_C_CLR = 3'b010,
      SEBP_C_SWR = 3'b011,
      SEBP_C_AWR = 3'b100,
      SEBP_C_ARD = 3'b101,
      SEBP_C_SRD = 3'b110
   } sebp_cmd_t;
endpackage

// ### rtl/sebp_sync.sv
// Two-flop synchroniser bank for pins from outside the clock domain.
// Reset clears both stages at once; a bank of one also releases reset.
module sebp_sync import sebp_pkg::*; #(
   parameter int unsigned N = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw pins and sampled copies
   input wire logic [N-1:0] d,
   output logic [N-1:0] q
);
   // First stage is read only by the second
   logic [N-1:0] meta_r;

   // One chain per bit
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_r[i] <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            meta_r[i] <= d[i];
            q[i] <= meta_r[i];
         end
      end
   end
endmodule // sebp_sync

// ### rtl/sebp_top.sv
// Serial bus front end of a byte-wide EEPROM: shifting, select, pause,
// status register, write protection and the self-timed write cycle.
// Assumes link pins are asynchronous to clk; array storage lives outside.
//
// Notes on behaviour
// - Output bits change on serial clock fall
// - Input bits captured on serial clock rise
// - Deselected means output in high impedance
// - Bytes travel most significant bit first
// - First bit on first rise after select
// - First output bit on fall after instruction or address
// - Select needs a chip select fall after power-up
// - Paused: output floats, clock and data ignored
// - Pause keeps received bits and bit position
// - Deselect during pause resets everything in progress
// - Pause edges count only with clock low
// - Status bits seven to four read one
// - Busy flag high for whole write cycle
// - Clear write latch refuses all writes
// - Protect bits choose protected array region
// - Write latch cleared at power-up
// - Invalid select and pause edges ignored
// - Execute only if deselected in byte window
// - During write cycle ignore array reads and writes
// - Write-protect pin blocks writes, never aborts
// - Decode latch set, clear, status read, write
// - Latch cleared on completion or protect low
// - Status write refused or only changes protect
module sebp_top import sebp_pkg::*; #(
   parameter int unsigned WR_CYCLES = WR_CYCLES_DFLT,
   parameter int unsigned AW = ADDR_W
) (
   // System clock and asynchronous reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial link pins
   input wire logic sck,
   input wire logic sdi,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic sdo,
   output logic sdo_oe_n,
   // Array side, same clock
   output logic [AW-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic wr_start,
   output logic [AW-1:0] wr_addr,
   output logic [7:0] wr_data,
   // Status for the host logic
   output logic [7:0] status
);
   // Whole state of the block
   typedef struct packed {
      logic sck_d;
      logic seen_high;
      logic sel;
      logic hold;
      sebp_state_t st;
      sebp_cmd_t cmd;
      logic [2:0] bcnt;
      logic [7:0] sh_in;
      logic a8;
      logic end_ok;
      logic drv;
      logic oe_n;
      logic so;
      logic [7:0] sh_out;
      logic write_enable_latch;
      logic [1:0] psel;
      logic [1:0] psel_new;
      logic wr_sr;
      logic [31:0] wcnt;
      logic wr_go;
      logic [AW-1:0] waddr;
      logic [7:0] wdata;
      logic [AW-1:0] raddr;
   } sebp_st_t;

   // Released copy of reset
   logic rst_s_n;
   // Sampled pins
   logic [4:0] pins_s;
   logic sck_s, sdi_s, cs_n_s, hold_n_s, wp_n_s;
   // State and next state
   sebp_st_t r, n;
   // Helpers
   logic rise, fall, active, busy, byte_done;
   logic [7:0] byte_in;
   logic [7:0] stat_byte;

   // Reset is applied at once but released through two flops
   sebp_sync #(.N(1)) u_rst (
      .clk(clk),
      .rst_n(rst_n),
      .d(1'b1),
      .q(rst_s_n)
   );
   // Every link pin crosses two flops before use
   sebp_sync #(.N(5)) u_sync (
      .clk(clk),
      .rst_n(rst_s_n),
      .d({sck, sdi, cs_n, hold_n, wp_n}),
      .q(pins_s)
   );
   assign {sck_s, sdi_s, cs_n_s, hold_n_s, wp_n_s} = pins_s;

   // Protected region test; top two address bits scale with array size
   function automatic logic prot(input logic [1:0] ps, input logic [AW-1:0] a);
      logic [1:0] top;
      top = a[AW-1 -: 2];
      unique case (ps)
         2'h0: prot = 1'b0;
         2'h1: prot = (top == 2'h3);
         2'h2: prot = top[1];
         2'h3: prot = 1'b1;
      endcase
   endfunction

   // Edges seen on the sampled serial clock
   assign rise = sck_s & ~r.sck_d;
   assign fall = ~sck_s & r.sck_d;
   // Shifting only while selected and not paused
   assign active = r.sel & ~cs_n_s & ~r.hold;
   assign busy = (r.wcnt != 32'h0);
   assign byte_in = {r.sh_in[6:0], sdi_s};
   assign byte_done = rise & active & (r.bcnt == BIT_LAST);
   // Upper nibble reads as ones
   assign stat_byte = {STAT_ONES, r.psel, r.write_enable_latch, busy};

   // Next-state logic
   always_comb begin
      n = r;
      n.wr_go = 1'b0;
      n.sck_d = sck_s;
      // Only a high level arms selection, so a low select at power-up waits
      n.seen_high = r.seen_high | cs_n_s;
      n.sel = r.seen_high & ~cs_n_s;
      // Pause edges only count while selected and with clock low
      if (r.sel && !cs_n_s) begin
         if (!sck_s) begin
            n.hold = ~hold_n_s;
         end
      end else begin
         n.hold = 1'b0;
      end

      // Serial input on rising clock, bit position kept across a pause
      if (rise && active) begin
         n.sh_in = byte_in;
         n.bcnt = r.bcnt + 3'h1;
         n.end_ok = 1'b0;
      end

      // Whole byte received
      if (byte_done) begin
         unique case (r.st)
            SEBP_CMD: begin
               n.a8 = byte_in[3];
               if (byte_in[7:4] != OP_HI) begin
                  n.st = SEBP_IGN;
               end else begin
                  // Lower three bits select the instruction
                  unique case (byte_in[2:0])
                     OP_LATCH_SET, OP_LATCH_CLEAR: begin
                        n.cmd = (byte_in[2:0] == OP_LATCH_SET) ? SEBP_C_SET : SEBP_C_CLR;
                        n.st = SEBP_WAIT;
                        n.end_ok = 1'b1;
                     end
                     OP_STATUS_READ: begin
                        n.cmd = SEBP_C_SRD;
                        n.st = SEBP_OUT;
                     end
                     OP_STATUS_WRITE: begin
                        n.cmd = SEBP_C_SWR;
                        n.st = SEBP_DATA;
                     end
                     OP_ARRAY_READ, OP_ARRAY_WRITE: begin
                        n.cmd = (byte_in[2:0] == OP_ARRAY_READ) ? SEBP_C_ARD : SEBP_C_AWR;
                        n.st = busy ? SEBP_IGN : SEBP_ADDR;
                     end
                     default: n.st = SEBP_IGN;
                  endcase
               end
            end
            SEBP_ADDR: begin
               // A8 rides in the instruction byte
               if (r.cmd == SEBP_C_ARD) begin
                  n.raddr = AW'({r.a8, byte_in});
                  n.st = SEBP_OUT;
               end else begin
                  n.waddr = AW'({r.a8, byte_in});
                  n.st = SEBP_DATA;
               end
            end
            SEBP_DATA: begin
               // Each data byte reopens the deselect window
               n.wdata = byte_in;
               n.psel_new = byte_in[STAT_PSEL_HI:STAT_PSEL_LO];
               n.end_ok = 1'b1;
            end
            SEBP_OUT: begin
               if (r.cmd == SEBP_C_ARD) begin
                  n.raddr = r.raddr + AW'(1);
               end
            end
            SEBP_WAIT: n.end_ok = 1'b1;
            SEBP_IGN: n.end_ok = 1'b0;
            default: n.st = SEBP_IGN;
         endcase
      end

      // Serial output on falling clock, byte loaded at each boundary
      if (fall && active && r.st == SEBP_OUT) begin
         n.drv = 1'b1;
         if (r.bcnt == 3'h0) begin
            // Status or array byte, most significant bit first
            if (r.cmd == SEBP_C_SRD) begin
               n.so = stat_byte[7];
               n.sh_out = {stat_byte[6:0], 1'b0};
            end else begin
               n.so = rd_data[7];
               n.sh_out = {rd_data[6:0], 1'b0};
            end
         end else begin
            n.so = r.sh_out[7];
            n.sh_out = {r.sh_out[6:0], 1'b0};
         end
      end

      // Self-timed write cycle; only a deselect during a pause can stop it
      if (busy) begin
         n.wcnt = r.wcnt - 32'h1;
         if (r.wcnt == 32'h1) begin
            n.write_enable_latch = 1'b0;
            if (r.wr_sr) begin
               // Protect bits stay frozen until the cycle ends
               n.psel = r.psel_new;
            end
         end
      end

      // Deselect: execute or abandon
      if (r.sel && cs_n_s) begin
         if (r.hold) begin
            // Deselect while paused abandons the write cycle and clears the write latch
            n.wcnt = 32'h0;
            n.write_enable_latch = 1'b0;
         end else if (r.end_ok) begin
            unique case (r.cmd)
               SEBP_C_SET: n.write_enable_latch = 1'b1;
               SEBP_C_CLR: n.write_enable_latch = 1'b0;
               SEBP_C_SWR: begin
                  if (r.write_enable_latch && !busy && wp_n_s) begin
                     n.wcnt = WR_CYCLES;
                     n.wr_sr = 1'b1;
                  end
               end
               SEBP_C_AWR: begin
                  if (r.write_enable_latch && !busy && wp_n_s && !prot(r.psel, r.waddr)) begin
                     n.wcnt = WR_CYCLES;
                     n.wr_sr = 1'b0;
                     n.wr_go = 1'b1;
                  end
               end
               default: n.write_enable_latch = r.write_enable_latch;
            endcase
         end
         n.st = SEBP_CMD;
         n.cmd = SEBP_C_NONE;
         n.bcnt = 3'h0;
         n.end_ok = 1'b0;
      end
      // Any deselect stops driving
      if (cs_n_s) begin
         n.drv = 1'b0;
      end

      // Protect pin low clears the latch and wins over a set
      if (!wp_n_s) begin
         n.write_enable_latch = 1'b0;
      end
      // Output floats unless selected, not paused and sending
      n.oe_n = ~(n.drv & n.sel & ~n.hold);
   end

   // State register; write latch and busy clear at power-up
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         r <= '{default: '0, st: SEBP_CMD, cmd: SEBP_C_NONE, oe_n: 1'b1, write_enable_latch: 1'b0,
                psel: PSEL_RST, psel_new: PSEL_RST};
      end else begin
         r <= n;
      end
   end

   // Outputs straight from flops, except the busy bit of status, decoded from the count
   assign sdo = r.so;
   assign sdo_oe_n = r.oe_n;
   assign rd_addr = r.raddr;
   assign wr_start = r.wr_go;
   assign wr_addr = r.waddr;
   assign wr_data = r.wdata;
   assign status = stat_byte;
   // Deselected pin gives a floating output next cycle
   property p_desel_float;
      @(posedge clk) disable iff (!rst_s_n) cs_n_s |=> sdo_oe_n;
   endproperty
   a_desel_float: assert property (p_desel_float)
      else $error("output driven while deselected");
   // Paused device never drives
   property p_hold_float;
      @(posedge clk) disable iff (!rst_s_n) r.hold |-> sdo_oe_n;
   endproperty
   a_hold_float: assert property (p_hold_float)
      else $error("output driven during pause");
   // Busy drops exactly when the count ends; no restart can overlap it
   property p_busy_end;
      @(posedge clk) disable iff (!rst_s_n) r.wcnt == 32'h1 |=> !status[STAT_BUSY];
   endproperty
   a_busy_end: assert property (p_busy_end)
      else $error("busy flag outlived the write cycle");
   // Protect pin clears the latch
   property p_wp_clear;
      @(posedge clk) disable iff (!rst_s_n) !wp_n_s |=> !status[STAT_WEL];
   endproperty
   a_wp_clear: assert property (p_wp_clear)
      else $error("write latch set while protect pin low");
   // A started array write needs the latch and an idle array
   property p_wr_needs_latch;
      @(posedge clk) disable iff (!rst_s_n)
      wr_start |-> $past(r.write_enable_latch) && $past(r.wcnt) == 32'h0 && $past(wp_n_s);
   endproperty
   a_wr_needs_latch: assert property (p_wr_needs_latch)
      else $error("array write started without permission");
   // No selection before a high select level has been seen
   property p_powerup_sel;
      @(posedge clk) disable iff (!rst_s_n) !r.seen_high |-> !r.sel;
   endproperty
   a_powerup_sel: assert property (p_powerup_sel)
      else $error("selected without a select fall");
   // First rising clock after select takes the first bit
   property p_first_bit;
      @(posedge clk) disable iff (!rst_s_n)
      (rise && active && r.st == SEBP_CMD && r.bcnt == 3'h0) |=> r.bcnt == 3'h1;
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first bit not taken");
   // Protect bits stay frozen while a cycle runs
   property p_psel_frozen;
      @(posedge clk) disable iff (!rst_s_n) (busy && r.wcnt != 32'h1) |=> $stable(r.psel);
   endproperty
   a_psel_frozen: assert property (p_psel_frozen)
      else $error("protect bits changed mid cycle");
   // Deselect while paused abandons the cycle
   property p_hold_abort;
      @(posedge clk) disable iff (!rst_s_n)
      (r.sel && cs_n_s && r.hold) |=> (r.wcnt == 32'h0 && r.st == SEBP_CMD);
   endproperty
   a_hold_abort: assert property (p_hold_abort)
      else $error("deselect during pause did not reset");
endmodule // sebp_top

// ### dv/sebp_mst.sv
// SPI master model that drives the serial pins of the EEPROM front end.
// Assumes the bench calls its tasks; every pin change lands on a clk fall.
module sebp_mst (
   // System clock
   input wire logic clk,
   // Pins toward the device
   output logic sck,
   output logic sdi,
   output logic cs_n,
   output logic hold_n,
   // Pins from the device
   input wire logic sdo,
   input wire logic sdo_oe_n,
   // Received byte for the bench
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   timeunit 1ns;
   timeprecision 1ns;

   logic cpol = 1'b0; // Idle clock level of the current frame

   // Select starts low to probe the edge-only select after reset
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
      cs_n = 1'b0;
      hold_n = 1'b1;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end

   // Half a link period: 6 clk, 24 ns
   task automatic half();
      repeat (6) @(negedge clk);
   endtask

   // Select in mode 0 (m=0) or mode 3 (m=1), clock parked first
   task automatic sel(input logic m);
      cpol = m;
      sck <= m;
      half();
      cs_n <= 1'b0;
      half();
   endtask

   // Shift n bits of b msb first; sample the line at each rise
   task automatic xfer(input logic [7:0] b, input int n, input logic chk);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sck <= 1'b0;
         sdi <= b[i];
         half();
         sck <= 1'b1;
         // A floating line is kept as z so it can never pass
         r = {r[6:0], sdo_oe_n ? 1'bz : sdo};
         half();
      end
      if (chk) begin
         rx_byte <= r;
         rx_stb <= 1'b1;
         @(negedge clk);
         rx_stb <= 1'b0;
      end
   endtask

   // Pause with the clock low, wiggle clock and data, maybe resume
   task automatic pause(input logic resume);
      sck <= 1'b0;
      half();
      hold_n <= 1'b0;
      half();
      repeat (4) begin
         sck <= ~sck;
         sdi <= ~sdi;
         half();
      end
      if (resume) begin
         hold_n <= 1'b1;
         half();
      end
   endtask

   // Release select between the last rise and the next one
   task automatic desel();
      if (!cpol && sck) begin
         sck <= 1'b0;
         half();
      end
      cs_n <= 1'b1;
      sdi <= ~sdi; // Released line shows no stale bit
      hold_n <= 1'b1;
      half();
      half();
   endtask
endmodule // sebp_mst

// ### dv/sebp_top_tb.sv
// Self-checking bench for the EEPROM serial front end and status logic.
// Assumes sebp_mst drives the link; array data is a pattern of the address.
module sebp_top_tb import sebp_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned WRC = 200; // Short write cycle, long enough to abort
   localparam int LIMIT = 40000; // Cycle ceiling for a hung run
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic [7:0] rd_data = 8'h00;
   logic sck, sdi, cs_n, hold_n, sdo, sdo_oe_n, wr_start, rx_stb;
   logic [ADDR_W-1:0] rd_addr, wr_addr;
   logic [7:0] wr_data, status, rx_byte;
   logic [7:0] rdq[$]; // Expected serial bytes
   logic [16:0] wrq[$]; // Expected write starts, address and data
   logic [1:0] psel_e = PSEL_RST; // Expected protect selection
   logic wel_e = 1'b0; // Expected write latch
   logic md = 1'b0; // Link mode of the next frames
   logic [7:0] rnd = 8'h15; // LFSR state
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   sebp_top #(.WR_CYCLES(WRC), .AW(ADDR_W)) i_sebp_top (
      .clk(clk), .rst_n(rst_n), .sck(sck), .sdi(sdi), .cs_n(cs_n),
      .hold_n(hold_n), .wp_n(wp_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_start(wr_start),
      .wr_addr(wr_addr), .wr_data(wr_data), .status(status));

   sebp_mst i_sebp_mst (
      .clk(clk), .sck(sck), .sdi(sdi), .cs_n(cs_n), .hold_n(hold_n),
      .sdo(sdo), .sdo_oe_n(sdo_oe_n), .rx_byte(rx_byte), .rx_stb(rx_stb));

   // Array content follows the low address byte
   always @(negedge clk) rd_data <= rd_addr[7:0] ^ 8'h5A;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t byte %h not %h", $time, g, e);
      end
   endtask

   task automatic cmp_wr(input logic [16:0] g, input logic [16:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t write start %h not %h", $time, g, e);
      end
   endtask

   task automatic cmp_stat(input logic [8:0] g, input logic [8:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t oe and status %h not %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Results as they appear, each against the oldest note
   always @(posedge clk) begin
      if (rx_stb)
         cmp_byte(rx_byte, rdq.size() ? rdq.pop_front() : 'x);
      if (wr_start)
         cmp_wr({wr_addr, wr_data}, wrq.size() ? wrq.pop_front() : 'x);
   end

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // Settle after deselect, then output must float and status match
   task automatic chk_stat(input logic busy);
      repeat (10) @(negedge clk);
      cmp_stat({sdo_oe_n, status}, {1'b1, STAT_ONES, psel_e, wel_e, busy});
   endtask

   // Bounded wait for the write cycle to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (status[STAT_BUSY] !== 1'b0 && n < 2 * WRC) begin
         @(negedge clk);
         n++;
      end
   endtask

   // One frame of nb bytes taken from the top of v
   task automatic send(input logic [23:0] v, input int nb);
      i_sebp_mst.sel(md);
      for (int i = 0; i < nb; i++)
         i_sebp_mst.xfer(v[23-8*i -: 8], 8, 1'b0);
      i_sebp_mst.desel();
   endtask

   // Frame of nb bytes, then two bytes read back
   task automatic rd(input logic [23:0] v, input int nb, input logic [7:0] e0,
                     input logic [7:0] e1);
      i_sebp_mst.sel(md);
      for (int i = 0; i < nb; i++)
         i_sebp_mst.xfer(v[23-8*i -: 8], 8, 1'b0);
      rdq.push_back(e0);
      i_sebp_mst.xfer(8'h00, 8, 1'b1);
      rdq.push_back(e1);
      i_sebp_mst.xfer(8'h00, 8, 1'b1);
      i_sebp_mst.desel();
   endtask

   task automatic setw();
      send({OP_HI, 1'b0, OP_LATCH_SET, 16'h0000}, 1);
      wel_e = 1'b1;
   endtask

   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk);
      // Bits clocked under a select that never fell do nothing
      i_sebp_mst.xfer({OP_HI, 1'b0, OP_LATCH_SET}, 8, 1'b0);
      i_sebp_mst.desel();
      chk_stat(1'b0);
      // Latch set, status read, latch clear; both modes, both X values
      for (int x = 0; x < 2; x++) begin
         md = x[0];
         send({OP_HI, x[0], OP_LATCH_SET, 16'h0000}, 1);
         wel_e = 1'b1;
         chk_stat(1'b0);
         rd({OP_HI, x[0], OP_STATUS_READ, 16'h0000}, 1, {STAT_ONES, psel_e, wel_e, 1'b0},
            {STAT_ONES, psel_e, wel_e, 1'b0});
         send({OP_HI, x[0], OP_LATCH_CLEAR, 16'h0000}, 1);
         wel_e = 1'b0;
         chk_stat(1'b0);
      end
      md = 1'b0;
      // A ninth bit closes the window
      i_sebp_mst.sel(1'b0);
      i_sebp_mst.xfer({OP_HI, 1'b0, OP_LATCH_SET}, 8, 1'b0);
      i_sebp_mst.xfer(8'h00, 1, 1'b0);
      i_sebp_mst.desel();
      chk_stat(1'b0);
      // Nonzero upper nibble: the instruction is ignored
      rnd = lfsr(rnd);
      send({rnd[7:4] | 4'h8, 1'b0, OP_LATCH_SET, 16'h0000}, 1);
      chk_stat(1'b0);
      send({OP_HI, 1'b0, OP_STATUS_WRITE, 8'h0F, 8'h00}, 2);
      chk_stat(1'b0);
      setw();
      send({OP_HI, 1'b0, OP_STATUS_WRITE, 8'h0F, 8'h00}, 2);
      chk_stat(1'b1);
      wait_idle();
      psel_e = 2'h3;
      wel_e = 1'b0;
      chk_stat(1'b0);
      // Whole array protected
      setw();
      rnd = lfsr(rnd);
      send({OP_HI, rnd[0], OP_ARRAY_WRITE, rnd, rnd}, 3);
      chk_stat(1'b0);
      // Only bits 3:2 of the data byte land
      send({OP_HI, 1'b0, OP_STATUS_WRITE, 8'hF7, 8'h00}, 2);
      wait_idle();
      psel_e = 2'h1;
      wel_e = 1'b0;
      chk_stat(1'b0);
      setw();
      rnd = lfsr(rnd);
      wrq.push_back({9'h17F, rnd});
      send({OP_HI, 1'b1, OP_ARRAY_WRITE, 8'h7F, rnd}, 3);
      chk_stat(1'b1);
      send({OP_HI, 1'b0, OP_ARRAY_WRITE, rnd, rnd}, 3);
      wait_idle();
      wel_e = 1'b0;
      chk_stat(1'b0);
      setw();
      send({OP_HI, 1'b1, OP_ARRAY_WRITE, 8'h80, rnd}, 3);
      chk_stat(1'b0);
      // Write protect clears the latch and blocks writes
      wp_n <= 1'b0;
      wel_e = 1'b0;
      chk_stat(1'b0);
      send({OP_HI, 1'b0, OP_LATCH_SET, 16'h0000}, 1);
      send({OP_HI, 1'b0, OP_STATUS_WRITE, 8'h00, 8'h00}, 2);
      chk_stat(1'b0);
      wp_n <= 1'b1;
      rnd = lfsr(rnd);
      rd({OP_HI, rnd[7], OP_ARRAY_READ, rnd[7:1], 1'b0, 8'h00}, 2,
         {rnd[7:1], 1'b0} ^ 8'h5A, {rnd[7:1], 1'b1} ^ 8'h5A);
      // Pause mid instruction keeps the bits already taken
      i_sebp_mst.sel(1'b0);
      i_sebp_mst.xfer({OP_HI, 1'b0, OP_LATCH_SET}, 4, 1'b0);
      i_sebp_mst.pause(1'b1);
      i_sebp_mst.xfer({1'b0, OP_LATCH_SET, 4'h0}, 4, 1'b0);
      i_sebp_mst.desel();
      wel_e = 1'b1;
      chk_stat(1'b0);
      // Deselect during pause aborts a running write
      rnd = lfsr(rnd);
      wrq.push_back({9'h050, rnd});
      send({OP_HI, 1'b0, OP_ARRAY_WRITE, 8'h50, rnd}, 3);
      i_sebp_mst.sel(1'b0);
      i_sebp_mst.xfer(8'h00, 2, 1'b0);
      i_sebp_mst.pause(1'b0);
      i_sebp_mst.desel();
      wel_e = 1'b0;
      chk_stat(1'b0);
      repeat (20) @(negedge clk);
      cmp_byte(8'(rdq.size() + wrq.size()), 8'h00);
      tally_and_finish();
   end
endmodule // sebp_top_tb
